// *** hw/mic_pkg.sv ***
// constants, register map and types of the interrupt controller
package mic_pkg;

    // register index on the plain register port
    localparam int          ADDR_W             = 3;
    localparam logic [2:0]  REG_IRQ_CONTROL    = 3'h0;
    localparam logic [2:0]  REG_OPTION         = 3'h1;
    localparam logic [2:0]  REG_PERIPH_FLAG    = 3'h2;
    localparam logic [2:0]  REG_PERIPH_ENABLE  = 3'h3;
    localparam logic [2:0]  REG_EVENT_STATUS   = 3'h4;
    localparam logic [2:0]  REG_EVENT_MASK     = 3'h5;
    localparam logic [2:0]  REG_CORE_STATE     = 3'h6;

    // irq_control_reg fields
    localparam int          BIT_GIE            = 7;
    localparam int          BIT_PERIPH_GROUP   = 6;
    localparam int          BIT_TIMER0_ENABLE  = 5;
    localparam int          BIT_PIN_ENABLE     = 4;
    localparam int          BIT_PORT_ENABLE    = 3;
    localparam int          BIT_TIMER0_FLAG    = 2;
    localparam int          BIT_PIN_FLAG       = 1;
    localparam int          BIT_PORT_FLAG      = 0;

    // option register field
    localparam int          BIT_EDGE_SELECT    = 6;

    // peripheral flag / enable layout
    localparam int          PERIPH_W           = 6;
    localparam int          PER_CONVERTER      = 0;
    localparam int          PER_TIMER1         = 1;
    localparam int          PER_TIMER2         = 2;
    localparam int          PER_CAPTURE        = 3;
    localparam int          PER_SERIAL         = 4;
    localparam int          PER_DISPLAY        = 5;

    // system event status / mask layout
    localparam int          EVENT_W            = 3;
    localparam int          EV_VECTOR          = 0;
    localparam int          EV_WAKE            = 1;
    localparam int          EV_RETURN          = 2;

    // values after reset
    localparam logic [7:0]  IRQ_CONTROL_RESET  = 8'h00;
    localparam logic [7:0]  OPTION_RESET       = 8'hff;
    localparam logic [5:0]  PERIPH_RESET       = 6'h00;
    localparam logic [2:0]  EVENT_RESET        = 3'h0;

    // vector and port widths
    localparam int          PC_W               = 13;
    localparam logic [12:0] VECTOR_ADDR        = 13'h0004;
    localparam int          PORT_CHANGE_W      = 4;

    // timing: clock and pin latency
    localparam int          CLK_PERIOD_NS      = 40;
    localparam int          LATENCY_MIN_CYCLES = 3;
    localparam int          LATENCY_MAX_CYCLES = 4;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQUEST,
        ST_SERVICE
    } mic_state_t;

endpackage

// *** hw/mic_pin_sync.sv ***
// two-stage synchroniser for pin inputs with one extra delayed copy
`timescale 1ns/1ps

module mic_pin_sync
    import mic_pkg::*;
#(
    parameter int WIDTH = 5
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_pins,
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_prev
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] prev_q;
    logic [2:0]       fill_q;

    ////////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_q  <= '0;
            level_q <= '0;
        end else begin
            meta_q  <= i_pins;
            level_q <= meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // delayed copy for edge and change detection
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            prev_q <= '0;
        end else begin
            prev_q <= level_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // marks when the delayed copy holds a real sample
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            fill_q <= 3'h0;
        end else begin
            fill_q <= {fill_q[1:0], 1'b1};
        end
    end

    // no false edge from a pin already high at reset release
    assign o_level = level_q;
    assign o_prev  = fill_q[2] ? prev_q : level_q;

endmodule // mic_pin_sync

// *** hw/mic_irq_ctrl.sv ***
// interrupt controller: flags, masks, global enable, vector request
// Functional notes
// - every source flag sets on its event, regardless of mask or global enable.
// - global enable bit 7 passes all unmasked sources when set, blocks all when clear.
// - with global enable set, any flagged and unmasked source requests a vector on the next clock.
// - reset clears the global enable, so nothing vectors until software sets it.
// - return-from-interrupt leaves the routine and sets the global enable again.
// - on acceptance clear global enable, push return address, load counter with 0004h.
// - pin and port-change events vector three or four cycles after the event.
// - external pin is edge triggered; option bit 6 picks rising, clear picks falling.
// - a valid pin edge sets flag bit 1; enable bit 4 masks it.
// - pin event wakes from sleep if enabled; global enable decides vectoring.
// - timer-0 rollover FFh to 00h sets flag bit 2; enable bit 5.
// - any change on port B pins 7:4 sets flag bit 0, gated by its own enable.
// - peripheral flags and enables in their own pair, gated by one group enable.
// - entry saves only the return counter; software saves working and status registers.
// - nine sources: pin, timer-0, port change and six peripheral sources.
// - an enabled flagged source wakes from sleep whatever the global enable.
`timescale 1ns/1ps

module mic_irq_ctrl
    import mic_pkg::*;
(
    input  wire logic                     i_clk,
    input  wire logic                     i_reset,
    // register port
    input  wire logic [ADDR_W-1:0]        i_addr,
    input  wire logic [7:0]               i_wdata,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic      [7:0]               o_rdata,
    // event sources
    input  wire logic                     i_external_irq_pin,
    input  wire logic [PORT_CHANGE_W-1:0] i_port_b_pins,
    input  wire logic                     i_timer0_rollover,
    input  wire logic [PERIPH_W-1:0]      i_periph_event,
    // core handshake
    input  wire logic                     i_irq_accept,
    input  wire logic                     i_return_from_irq_instr,
    input  wire logic                     i_sleeping,
    output logic                          o_vector_req,
    output logic                          o_push_return,
    output logic                          o_load_vector,
    output logic      [PC_W-1:0]          o_vector_pc,
    output logic                          o_wake,
    output logic                          o_global_irq_enable,
    // system interrupt
    output logic                          o_irq
);

    logic [7:0]          irq_control_reg_q;
    logic [7:0]          irq_control_reg_d;
    logic [7:0]          option_q;
    logic [PERIPH_W-1:0] peripheral_flag_reg_q;
    logic [PERIPH_W-1:0] peripheral_flag_reg_d;
    logic [PERIPH_W-1:0] peripheral_enable_reg_q;
    logic [EVENT_W-1:0]  event_status_q;
    logic [EVENT_W-1:0]  event_mask_q;
    logic [EVENT_W-1:0]  event_set;
    logic [7:0]          rdata_q;
    logic                vector_req_q;
    logic                push_return_q;
    logic                load_vector_q;
    logic [PC_W-1:0]     vector_pc_q;
    logic                wake_q;
    logic                irq_q;
    mic_state_t          state_q;
    mic_state_t          state_d;

    logic [PORT_CHANGE_W:0] pin_level;
    logic [PORT_CHANGE_W:0] pin_prev;
    logic                   pin_edge;
    logic                   port_change;
    logic                   core_pending;
    logic                   periph_pending;
    logic                   any_pending;
    logic                   req_now;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic wr_hit(input logic [ADDR_W-1:0] index);
        return i_wr && (i_addr == index);
    endfunction

    function automatic logic any_pair(input logic [PERIPH_W-1:0] flags,
                                      input logic [PERIPH_W-1:0] enables);
        return |(flags & enables);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: bit 0 external pin, bits 4:1 port B 7:4

    mic_pin_sync #(
        .WIDTH   (PORT_CHANGE_W + 1)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_pins  ({i_port_b_pins, i_external_irq_pin}),
        .o_level (pin_level),
        .o_prev  (pin_prev)
    );

    ////////////////////////////////////////////////////////////////////////////
    // event detection

    always_comb begin
        if (option_q[BIT_EDGE_SELECT]) begin
            pin_edge = pin_level[0] && !pin_prev[0];
        end else begin
            pin_edge = !pin_level[0] && pin_prev[0];
        end
    end

    assign port_change = |(pin_level[PORT_CHANGE_W:1] ^ pin_prev[PORT_CHANGE_W:1]);

    ////////////////////////////////////////////////////////////////////////////
    // pending terms

    assign periph_pending = irq_control_reg_q[BIT_PERIPH_GROUP]
                         && any_pair(peripheral_flag_reg_q, peripheral_enable_reg_q);

    // core pairs combined with the peripheral group
    assign core_pending = (irq_control_reg_q[BIT_PIN_FLAG]
                           && irq_control_reg_q[BIT_PIN_ENABLE])
                       || (irq_control_reg_q[BIT_TIMER0_FLAG]
                           && irq_control_reg_q[BIT_TIMER0_ENABLE])
                       || (irq_control_reg_q[BIT_PORT_FLAG]
                           && irq_control_reg_q[BIT_PORT_ENABLE]);

    assign any_pending = core_pending || periph_pending;

    // global enable passes or blocks every vector request
    assign req_now = irq_control_reg_q[BIT_GIE] && any_pending;

    ////////////////////////////////////////////////////////////////////////////
    // irq_control_reg next value

    always_comb begin
        irq_control_reg_d = irq_control_reg_q;
        if (wr_hit(REG_IRQ_CONTROL)) begin
            irq_control_reg_d = i_wdata;
        end
        if (i_irq_accept) begin
            irq_control_reg_d[BIT_GIE] = 1'b0;
        end else if (i_return_from_irq_instr) begin
            irq_control_reg_d[BIT_GIE] = 1'b1;
        end
        // set wins over a same-cycle clear
        if (pin_edge) begin
            irq_control_reg_d[BIT_PIN_FLAG] = 1'b1;
        end
        if (i_timer0_rollover) begin
            irq_control_reg_d[BIT_TIMER0_FLAG] = 1'b1;
        end
        if (port_change) begin
            irq_control_reg_d[BIT_PORT_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_control_reg_q <= IRQ_CONTROL_RESET;
        end else begin
            irq_control_reg_q <= irq_control_reg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // option register

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            option_q <= OPTION_RESET;
        end else if (wr_hit(REG_OPTION)) begin
            option_q <= i_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // peripheral flag and enable pair

    always_comb begin
        peripheral_flag_reg_d = peripheral_flag_reg_q;
        if (wr_hit(REG_PERIPH_FLAG)) begin
            peripheral_flag_reg_d = i_wdata[PERIPH_W-1:0];
        end
        peripheral_flag_reg_d = peripheral_flag_reg_d | i_periph_event;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            peripheral_flag_reg_q <= PERIPH_RESET;
        end else begin
            peripheral_flag_reg_q <= peripheral_flag_reg_d;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            peripheral_enable_reg_q <= PERIPH_RESET;
        end else if (wr_hit(REG_PERIPH_ENABLE)) begin
            peripheral_enable_reg_q <= i_wdata[PERIPH_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // service state

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (req_now) begin
                    state_d = ST_REQUEST;
                end
            end
            ST_REQUEST: begin
                if (i_irq_accept) begin
                    state_d = ST_SERVICE;
                end else if (!req_now) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SERVICE: begin
                if (i_return_from_irq_instr) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core handshake outputs

    // request follows pending with global enable
    // sync plus flag plus request gives three to four cycles
    // an uncleared flag re-raises this request once enabled
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            vector_req_q <= 1'b0;
        end else begin
            vector_req_q <= req_now && !i_irq_accept;
        end
    end

    // only the return counter is saved
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            push_return_q <= 1'b0;
            load_vector_q <= 1'b0;
            vector_pc_q   <= VECTOR_ADDR;
        end else begin
            push_return_q <= i_irq_accept;
            load_vector_q <= i_irq_accept;
            vector_pc_q   <= VECTOR_ADDR;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= i_sleeping && any_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system event status, mask and interrupt

    assign event_set = {i_return_from_irq_instr,
                        i_sleeping && any_pending && !wake_q,
                        i_irq_accept};

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            event_status_q <= EVENT_RESET;
        end else if (wr_hit(REG_EVENT_STATUS)) begin
            event_status_q <= (event_status_q & ~i_wdata[EVENT_W-1:0]) | event_set;
        end else begin
            event_status_q <= event_status_q | event_set;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            event_mask_q <= EVENT_RESET;
        end else if (wr_hit(REG_EVENT_MASK)) begin
            event_mask_q <= i_wdata[EVENT_W-1:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(event_status_q & event_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rdata_q <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                REG_IRQ_CONTROL:   rdata_q <= irq_control_reg_q;
                REG_OPTION:        rdata_q <= option_q;
                REG_PERIPH_FLAG:   rdata_q <= {2'h0, peripheral_flag_reg_q};
                REG_PERIPH_ENABLE: rdata_q <= {2'h0, peripheral_enable_reg_q};
                REG_EVENT_STATUS:  rdata_q <= {5'h00, event_status_q};
                REG_EVENT_MASK:    rdata_q <= {5'h00, event_mask_q};
                REG_CORE_STATE:    rdata_q <= {3'h0, wake_q, vector_req_q,
                                               any_pending, state_q};
                default:           rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_rdata             = rdata_q;
    assign o_vector_req        = vector_req_q;
    assign o_push_return       = push_return_q;
    assign o_load_vector       = load_vector_q;
    assign o_vector_pc         = vector_pc_q;
    assign o_wake              = wake_q;
    assign o_global_irq_enable = irq_control_reg_q[BIT_GIE];
    assign o_irq               = irq_q;

endmodule // mic_irq_ctrl

// *** tb/mic_irq_props.sv ***
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
module mic_irq_props
    import mic_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_reset,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [7:0]        i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [7:0]        o_rdata,
    input wire logic              i_external_irq_pin,
    input wire logic              i_timer0_rollover,
    input wire logic              i_irq_accept,
    input wire logic              i_return_from_irq_instr,
    input wire logic              i_sleeping,
    input wire logic              o_vector_req,
    input wire logic              o_push_return,
    input wire logic              o_load_vector,
    input wire logic [PC_W-1:0]   o_vector_pc,
    input wire logic              o_wake,
    input wire logic              o_global_irq_enable
);
    logic [7:0] ctl_q;
    logic [7:0] opt_q;

    // shadow of written enables and edge select
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctl_q <= IRQ_CONTROL_RESET;
            opt_q <= OPTION_RESET;
        end else if (i_wr) begin
            if (i_addr == REG_IRQ_CONTROL) ctl_q <= i_wdata;
            if (i_addr == REG_OPTION) opt_q <= i_wdata;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    ////////////////////////////////////////////////////////////
    sequence s_pin_edge;
        (opt_q[BIT_EDGE_SELECT] ? $rose(i_external_irq_pin) : $fell(i_external_irq_pin))
            && ctl_q[BIT_PIN_ENABLE] && o_global_irq_enable;
    endsequence
    sequence s_timer_armed;
        i_timer0_rollover && o_global_irq_enable && ctl_q[BIT_TIMER0_ENABLE];
    endsequence
    sequence s_quiet3;
        (o_global_irq_enable && !i_irq_accept)[*3];
    endsequence

    a_reset_gie_clear: assert property ($past(i_reset) |-> !o_global_irq_enable)
        else $error("global enable set right after reset");
    a_accept_enters_vector: assert property (i_irq_accept |=>
        !o_global_irq_enable && o_push_return && o_load_vector && !o_vector_req)
        else $error("accept did not push, load and clear enable");
    a_push_has_cause: assert property (o_push_return |-> $past(i_irq_accept))
        else $error("push without accept");
    a_vector_address: assert property (o_load_vector |-> o_vector_pc == VECTOR_ADDR)
        else $error("vector address wrong");
    a_return_sets_gie: assert property (i_return_from_irq_instr && !i_irq_accept
        |=> o_global_irq_enable)
        else $error("return did not set global enable");
    a_req_needs_gie: assert property (o_vector_req |-> $past(o_global_irq_enable))
        else $error("request while global enable clear");
    a_timer_req_time: assert property (s_timer_armed ##1
        (o_global_irq_enable && !i_irq_accept) |=> o_vector_req)
        else $error("timer request late");
    a_pin_latency: assert property (s_pin_edge ##1 s_quiet3 |=> o_vector_req)
        else $error("pin request later than four cycles");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_wake_in_sleep: assert property (o_wake |-> $past(i_sleeping))
        else $error("wake while awake");
endmodule // mic_irq_props

// *** tb/mic_core_model.sv ***
// core sequencer model: takes vectors after a set delay, issues returns
`timescale 1ns/1ps
module mic_core_model (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_vector_req,
    input  wire logic       i_gie,
    input  wire logic [3:0] i_delay,
    output logic            o_accept,
    output logic            o_return
);
    logic [3:0] cnt_q;
    logic       acc_q;

    initial o_return = 1'b0;

    // one accept per request, only the pc is saved by the device
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_accept <= 1'b0;
            acc_q    <= 1'b0;
            cnt_q    <= 4'h0;
        end else begin
            acc_q    <= o_accept;
            o_accept <= 1'b0;
            if (i_vector_req && i_gie && !o_accept && !acc_q) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == i_delay) begin
                    o_accept <= 1'b1;
                    cnt_q    <= 4'h0;
                end
            end else begin
                cnt_q <= 4'h0;
            end
        end
    end

    // return pulse, issued once the routine is done
    task automatic do_return();
        @(posedge i_clk);
        o_return <= 1'b1;
        @(posedge i_clk);
        o_return <= 1'b0;
    endtask
endmodule // mic_core_model

// *** tb/tb.sv ***
// testbench of the interrupt controller
`timescale 1ns/1ps
module tb;
    import mic_pkg::*;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, pin = 0, tmr = 0, slp = 0;
    logic [2:0]  addr = 0;
    logic [7:0]  wdata = 0;
    logic [3:0]  port_b_pins = 0, delay = 0;
    logic [5:0]  per = 0;
    logic [7:0]  rdata;
    logic [12:0] vpc;
    logic        acc, ret, vreq, push, load, wake, global_irq_enable, irq;
    int          failures = 0, n_tests = 0, lat;

    always #20 clk = ~clk;

    mic_irq_ctrl i_mic_irq_ctrl (.i_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_external_irq_pin(pin),
        .i_port_b_pins(port_b_pins), .i_timer0_rollover(tmr), .i_periph_event(per),
        .i_irq_accept(acc), .i_return_from_irq_instr(ret), .i_sleeping(slp),
        .o_vector_req(vreq), .o_push_return(push), .o_load_vector(load),
        .o_vector_pc(vpc), .o_wake(wake), .o_global_irq_enable(global_irq_enable), .o_irq(irq));
    mic_core_model i_mic_core_model (.i_clk(clk), .i_reset(rst), .i_vector_req(vreq),
        .i_gie(global_irq_enable), .i_delay(delay), .o_accept(acc), .o_return(ret));

    ////////////////////////////////////////////////////////////
    task automatic check(input string n, input logic [12:0] e, input logic [12:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("rdata", e, rdata);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic t, input logic [5:0] m);
        @(posedge clk);
        tmr <= t;
        per <= m;
        @(posedge clk);
        tmr <= 1'b0;
        per <= 6'h00;
    endtask
    task automatic wait_push();
        for (int i = 0; i < 40 && push !== 1'b1; i++) begin
            cyc(1);
        end
        check("push", 1'b1, push);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        test_done();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rreg(REG_IRQ_CONTROL, IRQ_CONTROL_RESET);
        rreg(REG_OPTION, OPTION_RESET);
        rreg(3'h7, 8'h00);
        check("vector_pc", VECTOR_ADDR, vpc);
        // masked event, then event racing a clear
        pulse(1'b1, 6'h00);
        rreg(REG_IRQ_CONTROL, 8'h04);
        check("vector_req", 1'b0, vreq);
        @(posedge clk);
        addr  <= REG_IRQ_CONTROL;
        wdata <= 8'h00;
        wr    <= 1'b1;
        tmr   <= 1'b1;
        @(posedge clk);
        wr  <= 1'b0;
        tmr <= 1'b0;
        rreg(REG_IRQ_CONTROL, 8'h04);
        // timer vector, return with flag left set, then cleared
        wreg(REG_IRQ_CONTROL, 8'ha0);
        pulse(1'b1, 6'h00);
        wait_push();
        check("gie", 1'b0, global_irq_enable);
        check("load", 1'b1, load);
        i_mic_core_model.do_return();
        wait_push();
        wreg(REG_IRQ_CONTROL, 8'h20);
        i_mic_core_model.do_return();
        cyc(3);
        check("gie", 1'b1, global_irq_enable);
        check("vector_req", 1'b0, vreq);
        // pin edges of both polarities, slow core
        delay <= 4'hf;
        for (int i = 0; i < 2; i++) begin
            wreg(REG_IRQ_CONTROL, 8'h10);
            wreg(REG_OPTION, i[0] ? 8'h40 : 8'h00);
            @(posedge clk);
            pin <= ~i[0];
            cyc(6);
            rreg(REG_IRQ_CONTROL, 8'h10);
            wreg(REG_IRQ_CONTROL, 8'h90);
            @(posedge clk);
            pin <= i[0];
            lat = 0;
            do begin
                cyc(1);
                lat++;
            end while (vreq !== 1'b1 && lat < 10);
            check("latency", 1'b1, lat >= 3 && lat <= 4);
            wait_push();
            rreg(REG_IRQ_CONTROL, 8'h12);
            wreg(REG_IRQ_CONTROL, 8'h00);
        end
        // port change group
        wreg(REG_IRQ_CONTROL, 8'h08);
        @(posedge clk);
        port_b_pins <= 4'h5;
        cyc(6);
        rreg(REG_IRQ_CONTROL, 8'h09);
        // peripheral sources behind the group enable
        delay <= 4'h1;
        wreg(REG_PERIPH_ENABLE, 8'h3f);
        wreg(REG_IRQ_CONTROL, 8'h80);
        pulse(1'b0, 6'h01);
        cyc(4);
        check("vector_req", 1'b0, vreq);
        for (int k = 0; k < PERIPH_W; k++) begin
            wreg(REG_PERIPH_FLAG, 8'h00);
            wreg(REG_IRQ_CONTROL, 8'hc0);
            pulse(1'b0, 6'h01 << k);
            wait_push();
            rreg(REG_PERIPH_FLAG, 8'h01 << k);
        end
        wreg(REG_PERIPH_FLAG, 8'h00);
        // status, mask and level interrupt
        wreg(REG_EVENT_MASK, 8'h01);
        cyc(2);
        check("irq", 1'b1, irq);
        wreg(REG_EVENT_MASK, 8'h00);
        cyc(2);
        check("irq", 1'b0, irq);
        wreg(REG_EVENT_STATUS, 8'h07);
        wreg(REG_EVENT_MASK, 8'h01);
        cyc(2);
        check("irq", 1'b0, irq);
        rreg(REG_EVENT_STATUS, 8'h00);
        // wake from sleep with global enable clear
        @(posedge clk);
        slp <= 1'b1;
        wreg(REG_IRQ_CONTROL, 8'h20);
        pulse(1'b1, 6'h00);
        cyc(3);
        check("wake", 1'b1, wake);
        check("vector_req", 1'b0, vreq);
        rreg(REG_CORE_STATE, 8'h16);
        @(posedge clk);
        slp <= 1'b0;
        // second reset in mid run
        wreg(REG_IRQ_CONTROL, 8'h80);
        @(posedge clk);
        rst <= 1'b1;
        cyc(2);
        check("gie", 1'b0, global_irq_enable);
        @(posedge clk);
        rst <= 1'b0;
        rreg(REG_IRQ_CONTROL, 8'h00);
        cyc(4);
        rreg(REG_IRQ_CONTROL, 8'h00);
        test_done();
    end
endmodule // tb

bind mic_irq_ctrl mic_irq_props i_mic_irq_props (.*);
